// ==== bench/sso_core_tb.sv ====
// sso_core_tb: self-checking bench for the subtract and sleep core
// assumes: rtl/sso_pkg.sv and rtl/sso_core.sv are compiled before this file
`timescale 1ns/100ps
`default_nettype none

module sso_core_tb;

  // ------------------------------------------------------------------
  // signals, counters and the design under test
  // ------------------------------------------------------------------
  logic                 sys_clk;
  logic                 rst;
  sso_pkg::sso_wb_req_t wb_req;
  sso_pkg::sso_wb_rsp_t wb_rsp;
  logic                 wake_pin;
  logic                 osc_run;
  logic                 asleep;
  int                   num_errors;
  int                   n_checks;
  int                   cnt;
  logic [31:0]          rd;
  logic [27:0]          tv [11];  // op, acc, operand, borrow-in, target

  sso_core sso_core_i (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .wb_req   (wb_req),
    .wb_rsp   (wb_rsp),
    .wake_pin (wake_pin),
    .osc_run  (osc_run),
    .asleep   (asleep)
  );

  // 40 MHz core clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------------
  // reporting and comparison
  // ------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ------------------------------------------------------------------
  // classic wishbone single cycles; held until ack is sampled high
  // ------------------------------------------------------------------
  task automatic wb_cycle(input logic we, input logic [7:0] adr,
                          input logic [31:0] wd, output logic [31:0] rdat);
    int                   n;
    sso_pkg::sso_wb_req_t r;
    r = '0;
    @(posedge sys_clk);
    r.cyc = 1'b1;
    r.stb = 1'b1;
    r.we  = we;
    r.adr = adr;
    r.sel = 4'hf;
    r.dat = wd;
    wb_req <= r;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 40);
    if (n >= 40) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end
    rdat = wb_rsp.dat;
    wb_req <= '0;
  endtask

  task automatic wb_wr(input logic [7:0] adr, input logic [31:0] wd);
    logic [31:0] x;
    wb_cycle(1'b1, adr, wd, x);
  endtask

  task automatic wb_rd(input logic [7:0] adr, output logic [31:0] v);
    wb_cycle(1'b0, adr, 32'h0, v);
  endtask

  // poll status until neither busy nor asleep, bounded
  task automatic wait_idle();
    int          n;
    logic [31:0] s;
    n = 0;
    do begin
      wb_rd(sso_pkg::ADR_STAT, s);
      n++;
    end while (s[6:5] !== 2'b00 && n < 30);
    if (n >= 30) chk32(s & 32'h60, 32'h0);
  endtask

  // expected {z, dc, c, diff} of m - s - borrow, borrow = ~nb
  function automatic logic [10:0] exp_sub(input logic [7:0] m,
                                          input logic [7:0] s,
                                          input logic nb);
    logic [8:0] full;
    logic [4:0] nib;
    full = {1'b0, m} - {1'b0, s} - {8'h00, ~nb};
    nib  = {1'b0, m[3:0]} - {1'b0, s[3:0]} - {4'h0, ~nb};
    return {full[7:0] == 8'h00, ~nib[4], ~full[8], full[7:0]};
  endfunction

  // one subtract: load operands, issue it, check both targets and flags
  task automatic run_case(input logic [27:0] v, input int i);
    logic [1:0]  op;
    logic [7:0]  acc;
    logic [7:0]  k;
    logic [7:0]  fa;
    logic        nb;
    logic        dest;
    logic [10:0] e;
    logic [31:0] r;
    op   = v[25:24];
    acc  = v[23:16];
    k    = v[15:8];
    nb   = v[4];
    dest = v[0];
    fa   = 8'(i + 5);
    e    = exp_sub(k, acc, (op == 2'd2) ? nb : 1'b1);
    wb_wr(sso_pkg::ADR_ACC, {24'h0, acc});
    wb_wr(sso_pkg::ADR_FADDR, {24'h0, fa});
    wb_wr(sso_pkg::ADR_FDATA, {24'h0, k});
    wb_wr(sso_pkg::ADR_STAT, {31'h0, nb});
    // odd register-subtract cases set the ignored top address bit of the operand
    wb_wr(sso_pkg::ADR_CMD, {20'h0, op, 1'b0, dest,
                             (op == 2'd0) ? k : {i[0], fa[6:0]}});
    wait_idle();
    wb_rd(sso_pkg::ADR_ACC, r);
    chk32(r, {24'h0, dest ? acc : e[7:0]});
    wb_rd(sso_pkg::ADR_FDATA, r);
    chk32(r, {24'h0, dest ? e[7:0] : k});
    wb_rd(sso_pkg::ADR_STAT, r);
    chk32({29'h0, r[2:0]}, {29'h0, e[10:8]});
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    rst        = 1'b1;
    wb_req     = '0;
    wake_pin   = 1'b0;
    num_errors = 0;
    n_checks   = 0;
    tv = '{28'h0050300, 28'h0030300, 28'h00f2000, 28'h000ff00,
           28'h1102500, 28'h1403001, 28'h17f7f01, 28'h2102500,
           28'h2252501, 28'h2252510, 28'h2010011};
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    // reset values and an unmapped word
    wb_rd(sso_pkg::ADR_STAT, rd);
    chk32(rd, 32'h18);
    wb_rd(sso_pkg::ADR_ACC, rd);
    chk32(rd, 32'h0);
    wb_wr(8'h3c, 32'h0000_00ff);
    wb_rd(8'h3c, rd);
    chk32(rd, 32'h0);
    // all three subtracts, both targets, borrow in and out
    for (int i = 0; i < 11; i++) begin
      run_case(tv[i], i);
    end
    // second command while the first executes is dropped
    wb_wr(sso_pkg::ADR_ACC, 32'h01);
    wb_wr(sso_pkg::ADR_CMD, 32'h0000_0010);
    wb_wr(sso_pkg::ADR_CMD, 32'h0000_0050);
    wait_idle();
    wb_rd(sso_pkg::ADR_ACC, rd);
    chk32(rd, 32'h0f);
    // let the watchdog prescaler run up before sleeping
    wb_wr(sso_pkg::ADR_WDOG, 32'h0001_0000);
    repeat (100) @(posedge sys_clk);
    wb_rd(sso_pkg::ADR_WDOG, rd);
    chk32({31'h0, rd[15:8] >= 8'h40}, 32'h1);
    // sleep: oscillator stops four cycles after the command commits
    wb_wr(sso_pkg::ADR_CMD, 32'h0000_0c00);
    cnt = 0;
    do begin
      @(posedge sys_clk);
      cnt++;
    end while (osc_run === 1'b1 && cnt < 20);
    chk_cnt(cnt - 1, sso_pkg::OSC_PER_TCY);
    chk32({31'h0, asleep}, 32'h1);
    // a command while asleep must not run
    wb_wr(sso_pkg::ADR_CMD, 32'h0000_0000);
    repeat (20) @(posedge sys_clk);
    chk32({31'h0, osc_run}, 32'h0);
    wake_pin <= 1'b1;
    cnt = 0;
    do begin
      @(posedge sys_clk);
      cnt++;
    end while (osc_run !== 1'b1 && cnt < 10);
    chk32({31'h0, osc_run}, 32'h1);
    wake_pin <= 1'b0;
    wb_rd(sso_pkg::ADR_WDOG, rd);
    chk32({30'h0, rd[7:0] == 8'h00, rd[15:8] < 8'h40}, 32'h3);
    wb_rd(sso_pkg::ADR_STAT, rd);
    chk32({28'h0, rd[6:3]}, 32'h2);
    wb_rd(sso_pkg::ADR_ACC, rd);
    chk32(rd, 32'h0f);
    report_and_stop();
  end

  // hang guard, well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    report_and_stop();
  end

endmodule // sso_core_tb

`default_nettype wire

// ==== rtl/sso_core.sv ====
// sso_core: subtract instructions, sleep and watchdog behind wishbone
// assumes: sys_clk stands for the oscillator; wake_pin is asynchronous
//
// Contract
// - literal subtract puts literal minus accumulator into accumulator.
// - literal subtract: borrow flags low if accumulator or nibble larger.
// - sleep clears power_down_flag and sets watchdog_expiry_flag.
// - sleep clears watchdog_counter and its prescaler.
// - after sleep the oscillator halts; nothing executes until a wake-up.
// - register subtract: register minus accumulator, same flag rules.
// - register subtract: target 0 writes accumulator, target 1 the register.
// - borrow subtract also takes the inverted carry; updates all flags.
// - borrow subtract: target 0 writes accumulator, target 1 the register.
// - every instruction cycle lasts exactly four oscillator periods.
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module sso_core (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire sso_pkg::sso_wb_req_t  wb_req,
  output var  sso_pkg::sso_wb_rsp_t  wb_rsp,
  input  wire logic                  wake_pin,
  output logic                       osc_run,
  output logic                       asleep
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  sso_pkg::sso_state_t  state;
  sso_pkg::sso_state_t  next_state;
  sso_pkg::sso_op_t     op_q;
  sso_pkg::sso_flags_t  alu_flags;
  logic [1:0]           phase;
  logic                 dest_q;
  logic [7:0]           opnd_q;
  logic [7:0]           acc;
  logic                 flag_c;
  logic                 flag_nib;
  logic                 flag_z;
  logic                 pwr_dn;
  logic                 expiry;
  logic                 wdog_en;
  logic [7:0]           wdog_cnt;
  logic [7:0]           wdog_pre;
  logic [6:0]           faddr;
  logic [7:0]           fmem [0:127];
  logic                 wake_meta;
  logic                 wake_sync;
  logic [7:0]           alu_diff;

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  wire        bus_req   = wb_req.cyc & wb_req.stb;
  wire        bus_wr    = bus_req & wb_req.we & wb_rsp.ack;
  wire        busy      = (state == sso_pkg::ST_EXEC);
  wire        sw_edit   = bus_wr & ~busy;       // no edits mid-instruction
  wire        hit_cmd   = (wb_req.adr == sso_pkg::ADR_CMD);
  wire        hit_acc   = (wb_req.adr == sso_pkg::ADR_ACC);
  wire        hit_stat  = (wb_req.adr == sso_pkg::ADR_STAT);
  wire        hit_faddr = (wb_req.adr == sso_pkg::ADR_FADDR);
  wire        hit_fdata = (wb_req.adr == sso_pkg::ADR_FDATA);
  wire        hit_wdog  = (wb_req.adr == sso_pkg::ADR_WDOG);
  wire        lane0     = wb_req.sel[0];
  wire [31:0] wdat      = wb_req.dat;

  // a command starts only from idle and needs both low byte lanes
  wire start = bus_wr & hit_cmd & (state == sso_pkg::ST_IDLE)
               & (wb_req.sel[1:0] == 2'h3);

  // ------------------------------------------------------------------
  // datapath selection
  // ------------------------------------------------------------------
  wire [7:0] f_rd     = fmem[opnd_q[6:0]];  // only 0..127 addressable
  wire       is_lit   = (op_q == sso_pkg::OP_LIT_SUB);
  wire [7:0] minuend  = is_lit ? opnd_q : f_rd;
  wire       no_brw   = (op_q == sso_pkg::OP_REG_SUBB) ? flag_c : 1'b1;
  wire       last_q   = busy & (phase == sso_pkg::Q_LAST);
  wire       exec_fin = last_q & (op_q != sso_pkg::OP_SLEEP);
  wire       sleep_go = last_q & (op_q == sso_pkg::OP_SLEEP);
  wire       to_acc   = exec_fin & (is_lit | ~dest_q);
  wire       to_file  = exec_fin & ~is_lit & dest_q;
  wire       wd_wrap  = wdog_en & (&wdog_pre) & (&wdog_cnt);
  wire       wake_now = (state == sso_pkg::ST_SLEEP) & (wake_sync | wd_wrap);

  // file register write port, shared by the core and the bus
  wire       mem_we = to_file | (sw_edit & hit_fdata & lane0);
  wire [6:0] mem_wa = to_file ? opnd_q[6:0] : faddr;
  wire [7:0] mem_wd = to_file ? alu_diff : wdat[7:0];

  // subtractor: minuend minus accumulator minus inverted borrow
  sso_sub_alu u_alu (
    .minuend      (minuend),
    .subtrahend   (acc),
    .no_borrow_in (no_brw),
    .diff         (alu_diff),
    .flags        (alu_flags)
  );

  // oscillator runs except while asleep
  assign osc_run = (state != sso_pkg::ST_SLEEP);
  assign asleep  = (state == sso_pkg::ST_SLEEP);

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  wire [31:0] rd_word =
    hit_cmd   ? {20'h0, op_q, 1'b0, dest_q, opnd_q} :
    hit_acc   ? {24'h0, acc} :
    hit_stat  ? {25'h0, asleep, busy, expiry, pwr_dn, flag_z, flag_nib,
                 flag_c} :
    hit_faddr ? {25'h0, faddr} :
    hit_fdata ? {24'h0, fmem[faddr]} :
    hit_wdog  ? {15'h0, wdog_en, wdog_pre, wdog_cnt} :
                32'h0;                             // unmapped reads zero

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  // next state: idle, four-phase execute, sleep
  always_comb begin
    next_state = state;
    case (state)
      sso_pkg::ST_IDLE: begin
        if (start) next_state = sso_pkg::ST_EXEC;
      end
      sso_pkg::ST_EXEC: begin
        if (sleep_go) next_state = sso_pkg::ST_SLEEP;
        else if (exec_fin) next_state = sso_pkg::ST_IDLE;
      end
      sso_pkg::ST_SLEEP: begin
        if (wake_now) next_state = sso_pkg::ST_IDLE;
      end
      default: next_state = sso_pkg::ST_IDLE;
    endcase
  end

  // state and phase counter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= sso_pkg::ST_IDLE;
      phase <= 2'h0;
    end else begin
      state <= next_state;
      phase <= busy ? phase + 2'h1 : 2'h0;
    end
  end

  // latch the command word
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      op_q   <= sso_pkg::OP_LIT_SUB;
      dest_q <= 1'b0;
      opnd_q <= 8'h00;
    end else if (start) begin
      op_q   <= sso_pkg::sso_op_t'(wdat[sso_pkg::CMD_OP_LSB +: 2]);
      dest_q <= wdat[sso_pkg::CMD_DEST_BIT];
      opnd_q <= wdat[sso_pkg::CMD_OPND_LSB +: 8];
    end
  end

  // wake pin synchroniser
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
    end else begin
      wake_meta <= wake_pin;
      wake_sync <= wake_meta;
    end
  end

  // ------------------------------------------------------------------
  // architectural registers
  // ------------------------------------------------------------------
  // accumulator
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) acc <= sso_pkg::ACC_RST;
    else if (to_acc) acc <= alu_diff;
    else if (sw_edit & hit_acc & lane0) acc <= wdat[7:0];
  end

  // file registers (no reset, like plain ram)
  always_ff @(posedge sys_clk) begin
    if (mem_we) fmem[mem_wa] <= mem_wd;
  end

  // file pointer for bus access
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) faddr <= sso_pkg::FADDR_RST;
    else if (sw_edit & hit_faddr & lane0) faddr <= wdat[6:0];
  end

  // arithmetic flags
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flag_c   <= sso_pkg::FLAG_RST;
      flag_nib <= sso_pkg::FLAG_RST;
      flag_z   <= sso_pkg::FLAG_RST;
    end else if (exec_fin) begin
      flag_c   <= alu_flags.c;
      flag_nib <= alu_flags.nib;
      flag_z   <= alu_flags.z;
    end else if (sw_edit & hit_stat & lane0) begin
      flag_c   <= wdat[sso_pkg::ST_C];
      flag_nib <= wdat[sso_pkg::ST_NIB];
      flag_z   <= wdat[sso_pkg::ST_Z];
    end
  end

  // power status: sleep wins over a same-cycle watchdog wrap
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwr_dn <= sso_pkg::PWR_DN_RST;
      expiry <= sso_pkg::EXPIRY_RST;
    end else if (sleep_go) begin
      pwr_dn <= 1'b0;
      expiry <= 1'b1;
    end else if (wd_wrap) begin
      expiry <= 1'b0;
    end
  end

  // watchdog enable
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) wdog_en <= sso_pkg::WDOG_EN_RST;
    else if (sw_edit & hit_wdog & wb_req.sel[2])
      wdog_en <= wdat[sso_pkg::WDOG_EN_BIT];
  end

  // watchdog prescaler and counter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wdog_pre <= sso_pkg::WDOG_RST;
      wdog_cnt <= sso_pkg::WDOG_RST;
    end else if (sleep_go) begin
      wdog_pre <= 8'h00;
      wdog_cnt <= 8'h00;
    end else if (wdog_en) begin
      wdog_pre <= wdog_pre + 8'h01;
      if (&wdog_pre) wdog_cnt <= wdog_cnt + 8'h01;
    end
  end

  // ------------------------------------------------------------------
  // wishbone answer: ack one cycle after the request, for one cycle
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wb_rsp <= '0;
    end else begin
      wb_rsp.ack <= bus_req & ~wb_rsp.ack;
      wb_rsp.dat <= (bus_req & ~wb_rsp.ack) ? rd_word : 32'h0;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_lit_result;
    (exec_fin && is_lit) |=> (acc == 8'($past(opnd_q) - $past(acc)));
  endproperty
  a_lit_result: assert property (p_lit_result)
    else $error("literal subtract result wrong");

  property p_lit_flags;
    (exec_fin && is_lit) |=>
      (flag_c == ($past(acc) <= $past(opnd_q))) &&
      (flag_nib == ($past(acc[3:0]) <= $past(opnd_q[3:0])));
  endproperty
  a_lit_flags: assert property (p_lit_flags)
    else $error("literal subtract borrow flags wrong");

  property p_sleep_flags;
    sleep_go |=> (!pwr_dn && expiry);
  endproperty
  a_sleep_flags: assert property (p_sleep_flags)
    else $error("sleep did not update power flags");

  property p_sleep_wdt;
    sleep_go |=> (wdog_cnt == 8'h00) && (wdog_pre == 8'h00);
  endproperty
  a_sleep_wdt: assert property (p_sleep_wdt)
    else $error("sleep did not clear watchdog");

  property p_sleep_halt;
    sleep_go ##1 !wake_now |=> (!osc_run && !busy && $stable(acc));
  endproperty
  a_sleep_halt: assert property (p_sleep_halt)
    else $error("core ran while asleep");

  property p_reg_sub;
    (exec_fin && op_q == sso_pkg::OP_REG_SUB && !dest_q) |=>
      (acc == 8'($past(f_rd) - $past(acc))) &&
      (flag_c == ($past(acc) <= $past(f_rd))) &&
      (flag_nib == ($past(acc[3:0]) <= $past(f_rd[3:0])));
  endproperty
  a_reg_sub: assert property (p_reg_sub)
    else $error("register subtract result or flags wrong");

  property p_reg_dest;
    (exec_fin && op_q == sso_pkg::OP_REG_SUB && dest_q) |=>
      (acc == $past(acc)) &&
      (fmem[$past(opnd_q[6:0])] == 8'($past(f_rd) - $past(acc)));
  endproperty
  a_reg_dest: assert property (p_reg_dest)
    else $error("register result landed in wrong place");

  property p_subb_result;
    (exec_fin && op_q == sso_pkg::OP_REG_SUBB && !dest_q) |=>
      (acc == 8'($past(f_rd) - $past(acc) - {7'h00, !$past(flag_c)}));
  endproperty
  a_subb_result: assert property (p_subb_result)
    else $error("subtract with borrow result wrong");

  property p_subb_dest;
    (exec_fin && op_q == sso_pkg::OP_REG_SUBB && dest_q) |=>
      (fmem[$past(opnd_q[6:0])] ==
       8'($past(f_rd) - $past(acc) - {7'h00, !$past(flag_c)}));
  endproperty
  a_subb_dest: assert property (p_subb_dest)
    else $error("subtract with borrow register result wrong");

  property p_four_phase;
    start |=> busy [*4] ##1 !busy;
  endproperty
  a_four_phase: assert property (p_four_phase)
    else $error("instruction cycle not four clocks");

  property p_zero_flag;
    exec_fin |=> (flag_z == ($past(alu_diff) == 8'h00));
  endproperty
  a_zero_flag: assert property (p_zero_flag)
    else $error("zero flag wrong");

endmodule // sso_core

`default_nettype wire

// ==== rtl/sso_pkg.sv ====
// sso_pkg: constants, types and bus carriers for the subtract/sleep core
// assumes: one 40 MHz core clock; registers reached over classic wishbone
package sso_pkg;

  // ------------------------------------------------------------------
  // register offsets (byte addresses, one aligned word each)
  // ------------------------------------------------------------------
  localparam logic [7:0] ADR_CMD   = 8'h00;
  localparam logic [7:0] ADR_ACC   = 8'h04;
  localparam logic [7:0] ADR_STAT  = 8'h08;
  localparam logic [7:0] ADR_FADDR = 8'h0c;
  localparam logic [7:0] ADR_FDATA = 8'h10;
  localparam logic [7:0] ADR_WDOG  = 8'h14;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int CMD_OPND_LSB = 0;   // 8-bit literal or file address
  localparam int CMD_DEST_BIT = 8;   // result_target_select
  localparam int CMD_OP_LSB   = 10;  // two-bit operation code
  localparam int ST_C         = 0;   // borrow_inverse_flag
  localparam int ST_NIB       = 1;   // nibble_borrow_inverse_flag
  localparam int ST_Z         = 2;   // result_null_flag
  localparam int WDOG_EN_BIT  = 16;

  // ------------------------------------------------------------------
  // values after reset
  // ------------------------------------------------------------------
  localparam logic [7:0] ACC_RST     = 8'h00;
  localparam logic [6:0] FADDR_RST   = 7'h00;
  localparam logic [7:0] WDOG_RST    = 8'h00;
  localparam logic       FLAG_RST    = 1'h0;
  localparam logic       PWR_DN_RST  = 1'h1;
  localparam logic       EXPIRY_RST  = 1'h1;
  localparam logic       WDOG_EN_RST = 1'h0;

  // ------------------------------------------------------------------
  // timing: one instruction cycle is four oscillator periods
  // ------------------------------------------------------------------
  localparam int         OSC_PERIOD_NS  = 25;
  localparam int         OSC_PER_TCY    = 4;
  localparam int         TCY_NS         = OSC_PER_TCY * OSC_PERIOD_NS;
  localparam int         TCY_CYCLES     = TCY_NS / OSC_PERIOD_NS;
  localparam logic [1:0] Q_LAST         = 2'(TCY_CYCLES - 1);

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_LIT_SUB,
    OP_REG_SUB,
    OP_REG_SUBB,
    OP_SLEEP
  } sso_op_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_SLEEP
  } sso_state_t;

  typedef struct packed {
    logic c;
    logic nib;
    logic z;
  } sso_flags_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } sso_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } sso_wb_rsp_t;

endpackage

// ==== rtl/sso_sub_alu.sv ====
// sso_sub_alu: 8-bit two's complement subtractor with borrow flags
// assumes: purely combinational, operands stable from the caller's flops
`timescale 1ns/100ps
`default_nettype none

module sso_sub_alu (
  input  wire logic [7:0]          minuend,
  input  wire logic [7:0]          subtrahend,
  input  wire logic                no_borrow_in,
  output logic [7:0]               diff,
  output sso_pkg::sso_flags_t      flags
);

  // ------------------------------------------------------------------
  // add the inverted subtrahend; carry out is the inverse of borrow
  // ------------------------------------------------------------------
  logic [8:0] full_sum;
  logic [4:0] low_sum;

  // whole byte and low nibble sums
  assign full_sum = {1'b0, minuend} + {1'b0, ~subtrahend}
                    + {8'h00, no_borrow_in};
  assign low_sum  = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]}
                    + {4'h0, no_borrow_in};

  // result and flags
  assign diff  = full_sum[7:0];
  assign flags = {full_sum[8], low_sum[4], (full_sum[7:0] == 8'h00)};

endmodule // sso_sub_alu

`default_nettype wire
